// File: design/uacs_consts.svh
// constants of the uart control and status block
//
// Contract
// R1: loop without source select feeds receiver internally
// R2: loop with source select reads serial out pin
// R3: tx empty irq only while its enable set
// R4: tx done irq only while its enable set
// R5: rx full or overrun irq gated by enable
// R6: idle irq only while its enable set
// R7: xmit_on enables transmitter, queues idle preamble
// R8: receiver runs only while rcv_on set
// R9: standby wakes on idle, suppresses rx irqs
// R10: toggled break_send sends exactly one break
// R11: held break_send sends breaks back to back
// R12: software reads status before data access
// R13: writes to first status register ignored
// R14: tx_buf_empty sets when shifter takes byte
// R15: tx_buf_empty clears by status read, data write
// R16: tx_done low while busy, line idles high
// R17: tx_done clears by sequence or queueing, clear wins
// R18: rx_buf_full sets on transfer, clears by sequence
// R19: idle after 10 or 11 ones
// R20: idle clears by sequence, rearms after frame
// R21: software enables both directions before loop
// R22: char_len_sel picks eight or nine data bits
// R23: standby stops idle line setting idle flag
// R24: long_break_sel adds three break bits
// R25: one irq output ORs gated flags
`ifndef UACS_CONSTS_SVH
`define UACS_CONSTS_SVH
`define UACS_ADDR_CTRL1 3'h0
`define UACS_ADDR_CTRL2 3'h1
`define UACS_ADDR_STAT1 3'h2
`define UACS_ADDR_STAT2 3'h3
`define UACS_ADDR_DATAH 3'h4
`define UACS_ADDR_DATAL 3'h5
`define UACS_C1_LOOP 7
`define UACS_C1_SRC 5
`define UACS_C1_CHAR_LEN 4
`define UACS_C1_MASK 8'hb0
`define UACS_C2_TX_EMPTY_IRQ_EN 7
`define UACS_C2_TX_DONE_IRQ_EN 6
`define UACS_C2_RX_FULL_IRQ_EN 5
`define UACS_C2_IDLE_IRQ_EN 4
`define UACS_C2_XMIT_ON 3
`define UACS_C2_RCV_ON 2
`define UACS_C2_RX_STANDBY 1
`define UACS_C2_BREAK_SEND 0
`define UACS_S2_LONG_BREAK 2
`define UACS_DH_T8 6
`define UACS_CTRL_RST 8'h00
`define UACS_BIT_CYCLES 8'd16
`define UACS_BIT_LAST 8'd15
`define UACS_HALF_BIT 8'd7
`define UACS_FRAME8 4'd10
`define UACS_FRAME9 4'd11
`define UACS_BRK_EXTRA 4'd3
`endif

// File: design/uacs_pkg.sv
// types of the uart control and status block
package uacs_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_BRK, TX_DATA} uacs_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uacs_rx_st_t;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} uacs_bus_req_t;
	typedef struct packed {
		logic [7:0]  ctrl1;
		logic [7:0]  ctrl2;
		logic        long_brk;
		logic        t8;
		logic [7:0]  tdr;
		logic [8:0]  rdr;
		logic        tx_buf_empty;
		logic        tc;
		logic        rx_buf_full;
		logic        idle;
		logic        ovr;
		logic        arm_tx_buf_empty;
		logic        arm_tc;
		logic        arm_rx_buf_full;
		logic        arm_idle;
		logic        arm_ovr;
		logic        te_d;
		logic        pre_pend;
		uacs_tx_st_t tx_st;
		logic [10:0] tx_sh;
		logic        tx_fill;
		logic [3:0]  tx_left;
		logic [7:0]  tx_baud;
		uacs_rx_st_t rx_st;
		logic [8:0]  rx_sh;
		logic [3:0]  rx_cnt;
		logic [7:0]  rx_baud;
		logic [7:0]  ones;
		logic        idle_ok;
		logic [7:0]  rdata;
		logic        txd;
		logic        txd_oe;
		logic        irq;
	} uacs_state_t;
endpackage

// File: design/uacs_top.sv
// uart control and status: registers, flags, framing, loop and break
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "uacs_consts.svh"
module uacs_top
	import uacs_pkg::*;
(
	input  wire logic          core_clk_i,  // 50 MHz block clock
	input  wire logic          rst_b_i,     // async reset, active low
	input  wire uacs_bus_req_t bus_i,       // register access request
	output logic [7:0]         rdata_o,     // read data, cycle after read
	input  wire logic          rxd_i,       // receive pin
	input  wire logic          txd_i,       // level seen on serial out pin
	output logic               txd_o,       // serial out pin drive value
	output logic               txd_oe_o,    // serial out pin enable
	output logic               irq_o        // interrupt request, high
);
	uacs_state_t s;       // whole block state
	uacs_state_t n;       // next value of the state
	logic        m_9;     // nine data bit format
	logic        rx_in;   // receiver input after loop selection
	logic        wr_datl; // write of the low data register
	logic        rd_datl; // read of the low data register
	logic        sw_tc;   // software clear of tx_done

	// frame length in bits for the selected format
	function automatic logic [3:0] frame_bits(input logic nine);
		frame_bits = nine ? `UACS_FRAME9 : `UACS_FRAME8;
	endfunction

	// clocks of line high that make an idle character
	function automatic logic [7:0] idle_clks(input logic nine);
		idle_clks = 8'(frame_bits(nine)) * `UACS_BIT_CYCLES;
	endfunction

	assign m_9 = s.ctrl1[`UACS_C1_CHAR_LEN]; // R22
	// loop routes the tx line, single wire the pin level
	assign rx_in = !s.ctrl1[`UACS_C1_LOOP] ? rxd_i :
		(s.ctrl1[`UACS_C1_SRC] ? txd_i : s.txd); // R1 R2
	assign wr_datl = bus_i.wr && bus_i.addr == `UACS_ADDR_DATAL;
	assign rd_datl = bus_i.rd && bus_i.addr == `UACS_ADDR_DATAL;
	assign sw_tc   = wr_datl && s.arm_tc;

	// next state: bus, transmitter, receiver, outputs
	always_comb begin
		n = s;
		n.te_d  = s.ctrl2[`UACS_C2_XMIT_ON];
		n.rdata = 8'h00;
		// register writes; the first status register takes none
		if (bus_i.wr) begin
			case (bus_i.addr)
				`UACS_ADDR_CTRL1: n.ctrl1 = bus_i.wdata & `UACS_C1_MASK;
				`UACS_ADDR_CTRL2: n.ctrl2 = bus_i.wdata;
				`UACS_ADDR_STAT2: n.long_brk = bus_i.wdata[`UACS_S2_LONG_BREAK];
				`UACS_ADDR_DATAH: n.t8 = bus_i.wdata[`UACS_DH_T8];
				`UACS_ADDR_DATAL: n.tdr = bus_i.wdata;
				default: ; // R13
			endcase
		end
		// register reads, answered in the next cycle
		if (bus_i.rd) begin
			case (bus_i.addr)
				`UACS_ADDR_CTRL1: n.rdata = s.ctrl1;
				`UACS_ADDR_CTRL2: n.rdata = s.ctrl2;
				`UACS_ADDR_STAT1: n.rdata = {s.tx_buf_empty, s.tc, s.rx_buf_full, s.idle, s.ovr, 3'h0};
				`UACS_ADDR_STAT2: n.rdata = {5'h00, s.long_brk, 2'h0};
				`UACS_ADDR_DATAH: n.rdata = {s.rdr[8], s.t8, 6'h00};
				`UACS_ADDR_DATAL: n.rdata = s.rdr[7:0];
				default: n.rdata = 8'h00; // unmapped reads as zero
			endcase
		end
		// a status read arms the clear of each flag it saw set
		if (bus_i.rd && bus_i.addr == `UACS_ADDR_STAT1) begin
			n.arm_tx_buf_empty = s.tx_buf_empty;
			n.arm_tc   = s.tc;
			n.arm_rx_buf_full = s.rx_buf_full;
			n.arm_idle = s.idle;
			n.arm_ovr  = s.ovr;
		end
		// data write completes the transmit side clear
		if (wr_datl) begin
			if (s.arm_tx_buf_empty) begin
				n.tx_buf_empty = 1'b0; // R15
			end
			n.arm_tx_buf_empty = 1'b0;
			n.arm_tc   = 1'b0;
		end
		// data read completes the receive side clears, before any set
		if (rd_datl) begin
			if (s.arm_rx_buf_full) begin
				n.rx_buf_full = 1'b0; // R18
			end
			if (s.arm_idle) begin
				n.idle = 1'b0; // R20
			end
			if (s.arm_ovr) begin
				n.ovr = 1'b0;
			end
			n.arm_rx_buf_full = 1'b0;
			n.arm_idle = 1'b0;
			n.arm_ovr  = 1'b0;
		end
		// enabling the transmitter queues one idle preamble
		if (s.ctrl2[`UACS_C2_XMIT_ON] && !s.te_d) begin
			n.pre_pend = 1'b1; // R7
		end
		// transmitter; a disable lets the running frame finish on txd_o, but txd_oe_o releases the pin on the next clock
		case (s.tx_st)
			TX_IDLE: begin
				// te_d holds off one cycle so the preamble goes first
				if (s.ctrl2[`UACS_C2_XMIT_ON] && s.te_d) begin // R7
					if (s.pre_pend) begin
						n.pre_pend = 1'b0;
						n.tx_sh    = 11'h7ff;
						n.tx_fill  = 1'b1;
						n.tx_left  = frame_bits(m_9);
						n.tx_baud  = 8'h00;
						n.tx_st    = TX_PRE;
					end else if (s.ctrl2[`UACS_C2_BREAK_SEND]) begin // R10 R11
						n.tx_sh   = 11'h000;
						n.tx_fill = 1'b0;
						n.tx_left = frame_bits(m_9) +
							(s.long_brk ? `UACS_BRK_EXTRA : 4'h0); // R24
						n.tx_baud = 8'h00;
						n.tx_st   = TX_BRK;
					end else if (!s.tx_buf_empty) begin
						// stop, ninth or stop, data, start; lsb first
						n.tx_sh   = {1'b1, m_9 ? s.t8 : 1'b1, s.tdr, 1'b0};
						n.tx_fill = 1'b1;
						n.tx_left = frame_bits(m_9);
						n.tx_baud = 8'h00;
						n.tx_st   = TX_DATA;
						n.tx_buf_empty    = 1'b1; // R14
					end
				end
			end
			TX_PRE, TX_BRK, TX_DATA: begin
				n.tx_baud = s.tx_baud + 8'h01;
				if (s.tx_baud == `UACS_BIT_LAST) begin
					n.tx_baud = 8'h00;
					n.tx_sh   = {s.tx_fill, s.tx_sh[10:1]};
					n.tx_left = s.tx_left - 4'h1;
					if (s.tx_left == 4'h1) begin
						n.tx_st = TX_IDLE;
					end
				end
			end
			default: n.tx_st = TX_IDLE;
		endcase
		// tx_done: high only when all is quiet; the clear wins a tie
		n.tc = n.tx_st == TX_IDLE && n.tx_buf_empty && !n.pre_pend &&
			!(n.ctrl2[`UACS_C2_BREAK_SEND] && n.ctrl2[`UACS_C2_XMIT_ON]) &&
			!sw_tc; // R16 R17
		// receiver, held in idle while disabled
		if (!s.ctrl2[`UACS_C2_RCV_ON]) begin
			n.rx_st = RX_IDLE; // R8
			n.ones  = 8'h00;
		end else begin
			case (s.rx_st)
				RX_IDLE: begin
					if (!rx_in) begin
						n.rx_st   = RX_START;
						n.rx_baud = 8'h00;
						n.ones    = 8'h00;
					end else if (s.ones < idle_clks(m_9)) begin
						n.ones = s.ones + 8'h01;
						// one full idle character seen
						if (s.ones == idle_clks(m_9) - 8'h01) begin // R19
							if (s.ctrl2[`UACS_C2_RX_STANDBY]) begin
								n.ctrl2[`UACS_C2_RX_STANDBY] = 1'b0; // R9 R23
							end else if (s.idle_ok) begin
								n.idle    = 1'b1;
								n.idle_ok = 1'b0; // R20
							end
						end
					end
				end
				RX_START: begin
					// recheck mid start bit to reject glitches
					n.rx_baud = s.rx_baud + 8'h01;
					if (s.rx_baud == `UACS_HALF_BIT) begin
						n.rx_baud = 8'h00;
						n.rx_cnt  = 4'h0;
						n.rx_st   = rx_in ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					n.rx_baud = s.rx_baud + 8'h01;
					if (s.rx_baud == `UACS_BIT_LAST) begin
						n.rx_baud = 8'h00;
						n.rx_sh   = {rx_in, s.rx_sh[8:1]};
						n.rx_cnt  = s.rx_cnt + 4'h1;
						if (s.rx_cnt == (m_9 ? 4'h8 : 4'h7)) begin // R22
							n.rx_st = RX_STOP;
						end
					end
				end
				RX_STOP: begin
					// stop level is not checked; no framing error is flagged
					n.rx_baud = s.rx_baud + 8'h01;
					if (s.rx_baud == `UACS_BIT_LAST) begin
						n.rx_st = RX_IDLE;
						n.ones  = 8'h00;
						// in standby frames are dropped, no flags move
						if (!s.ctrl2[`UACS_C2_RX_STANDBY]) begin
							if (n.rx_buf_full) begin
								n.ovr = 1'b1;
							end else begin
								n.rdr     = m_9 ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
								n.rx_buf_full    = 1'b1; // R18
								n.idle_ok = 1'b1; // R20
							end
						end
					end
				end
				default: n.rx_st = RX_IDLE;
			endcase
		end
		// registered pin and request outputs
		n.txd    = n.tx_st == TX_IDLE ? 1'b1 : n.tx_sh[0]; // R16
		n.txd_oe = n.ctrl2[`UACS_C2_XMIT_ON]; // R7
		n.irq    = (n.tx_buf_empty && n.ctrl2[`UACS_C2_TX_EMPTY_IRQ_EN]) || // R3
			(n.tc && n.ctrl2[`UACS_C2_TX_DONE_IRQ_EN]) || // R4
			((n.rx_buf_full || n.ovr) && n.ctrl2[`UACS_C2_RX_FULL_IRQ_EN] &&
			 !n.ctrl2[`UACS_C2_RX_STANDBY]) || // R5 R9
			(n.idle && n.ctrl2[`UACS_C2_IDLE_IRQ_EN] &&
			 !n.ctrl2[`UACS_C2_RX_STANDBY]); // R6 R25
	end

	// state register; flags start empty-buffer and done
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s          <= '0;
			s.ctrl1    <= `UACS_CTRL_RST;
			s.ctrl2    <= `UACS_CTRL_RST;
			s.tx_buf_empty     <= 1'b1;
			s.tc       <= 1'b1;
			s.idle_ok  <= 1'b1;
			s.tx_sh    <= 11'h7ff;
			s.tx_fill  <= 1'b1;
			s.tx_st    <= TX_IDLE;
			s.rx_st    <= RX_IDLE;
			s.txd      <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign rdata_o  = s.rdata;
	assign txd_o    = s.txd;
	assign txd_oe_o = s.txd_oe;
	assign irq_o    = s.irq;

	// checks on the block's own behaviour
	localparam int BRK_SHORT = 10 * `UACS_BIT_CYCLES - 1;
	localparam int BRK_LONG  = (`UACS_FRAME8 + `UACS_BRK_EXTRA) * `UACS_BIT_CYCLES - 1;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_see_tx_buf_empty;
		bus_i.rd && bus_i.addr == `UACS_ADDR_STAT1 && s.tx_buf_empty;
	endsequence
	sequence s_see_rx_buf_full;
		bus_i.rd && bus_i.addr == `UACS_ADDR_STAT1 && s.rx_buf_full;
	endsequence
	sequence s_brk_start;
		s.tx_st == TX_IDLE && !s.long_brk && !m_9 ##1 s.tx_st == TX_BRK;
	endsequence

	property p_tx_buf_empty_irq;
		s.tx_buf_empty && s.ctrl2[`UACS_C2_TX_EMPTY_IRQ_EN] |-> irq_o;
	endproperty
	a_tx_buf_empty_irq: assert property (p_tx_buf_empty_irq) else $error("tx empty irq missing"); // R3
	property p_tc_irq;
		s.tc && s.ctrl2[`UACS_C2_TX_DONE_IRQ_EN] |-> irq_o;
	endproperty
	a_tc_irq: assert property (p_tc_irq) else $error("tx done irq missing"); // R4
	property p_irq_off;
		s.ctrl2[7:4] == 4'h0 |-> !irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq with all enables off"); // R5
	property p_idle_irq;
		s.idle && s.ctrl2[`UACS_C2_IDLE_IRQ_EN] && !s.ctrl2[`UACS_C2_RX_STANDBY] |-> irq_o;
	endproperty
	a_idle_irq: assert property (p_idle_irq) else $error("idle irq missing"); // R6
	property p_rx_off;
		!s.ctrl2[`UACS_C2_RCV_ON] |=> s.rx_st == RX_IDLE;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("receiver ran while off"); // R8
	property p_st1_wr;
		bus_i.wr && bus_i.addr == `UACS_ADDR_STAT1 |=> $stable(s.ctrl1) && $stable(s.tdr);
	endproperty
	a_st1_wr: assert property (p_st1_wr) else $error("status write had effect"); // R13
	property p_tx_buf_empty_clr;
		s_see_tx_buf_empty ##1 wr_datl |=> !s.tx_buf_empty;
	endproperty
	a_tx_buf_empty_clr: assert property (p_tx_buf_empty_clr) else $error("tx empty not cleared"); // R15
	property p_rx_buf_full_clr;
		s_see_rx_buf_full ##1 (rd_datl && s.rx_st != RX_STOP) |=> !s.rx_buf_full;
	endproperty
	a_rx_buf_full_clr: assert property (p_rx_buf_full_clr) else $error("rx full not cleared"); // R18
	property p_tc_busy;
		s.tx_st != TX_IDLE || s.pre_pend |-> !s.tc;
	endproperty
	a_tc_busy: assert property (p_tc_busy) else $error("tx done while busy"); // R16
	property p_tc_line;
		s.tc |-> txd_o;
	endproperty
	a_tc_line: assert property (p_tc_line) else $error("line not idle when done"); // R16
	property p_brk_len;
		s_brk_start |-> ##BRK_SHORT s.tx_st == TX_BRK && !txd_o ##1 s.tx_st == TX_IDLE;
	endproperty
	a_brk_len: assert property (p_brk_len) else $error("break length wrong"); // R10
	property p_standby_idle;
		s.ctrl2[`UACS_C2_RX_STANDBY] && !s.idle |=> !s.idle;
	endproperty
	a_standby_idle: assert property (p_standby_idle) else $error("idle set in standby"); // R23
	// software usually puts other bus work between the status read and the access
	property p_tx_buf_empty_clr_gap;
		s_see_tx_buf_empty ##1 !wr_datl ##1 wr_datl |=> !s.tx_buf_empty;
	endproperty
	a_tx_buf_empty_clr_gap: assert property (p_tx_buf_empty_clr_gap) else $error("tx empty kept"); // R15
	property p_rx_buf_full_clr_gap;
		s_see_rx_buf_full ##1 !rd_datl ##1 (rd_datl && s.rx_st != RX_STOP) |=> !s.rx_buf_full;
	endproperty
	a_rx_buf_full_clr_gap: assert property (p_rx_buf_full_clr_gap) else $error("rx full kept"); // R18
	// the byte leaves the data register in the cycle the frame loads
	property p_tx_buf_empty_set;
		s.tx_st == TX_IDLE ##1 s.tx_st == TX_DATA |-> s.tx_buf_empty;
	endproperty
	a_tx_buf_empty_set: assert property (p_tx_buf_empty_set) else $error("tx empty not set on load"); // R14
	// a software clear beats a set in the same cycle
	property p_tc_clr;
		sw_tc |=> !s.tc;
	endproperty
	a_tc_clr: assert property (p_tc_clr) else $error("tx done survived clear"); // R17
	// either receive flag asks for service while enabled and awake
	property p_rx_irq;
		(s.rx_buf_full || s.ovr) && s.ctrl2[`UACS_C2_RX_FULL_IRQ_EN] &&
			!s.ctrl2[`UACS_C2_RX_STANDBY] |-> irq_o;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx full irq missing"); // R5
	// standby hides every receiver request; transmit requests still pass
	property p_standby_mask;
		s.ctrl2[`UACS_C2_RX_STANDBY] && s.ctrl2[7:6] == 2'h0 |-> !irq_o;
	endproperty
	a_standby_mask: assert property (p_standby_mask) else $error("rx irq in standby"); // R9
	// the pin belongs to the transmitter exactly while it is enabled
	property p_tx_oe;
		txd_oe_o == s.ctrl2[`UACS_C2_XMIT_ON];
	endproperty
	a_tx_oe: assert property (p_tx_oe) else $error("pin enable off its bit"); // R7
	// one full idle character on an armed, awake receiver sets the flag
	property p_idle_set;
		s.ctrl2[`UACS_C2_RCV_ON] && !s.ctrl2[`UACS_C2_RX_STANDBY] && s.rx_st == RX_IDLE &&
			rx_in && s.idle_ok && s.ones == idle_clks(m_9) - 8'h01 |=> s.idle;
	endproperty
	a_idle_set: assert property (p_idle_set) else $error("idle not set"); // R19
	property p_idle_rearm;
		!s.idle && !s.idle_ok |=> !s.idle;
	endproperty
	a_idle_rearm: assert property (p_idle_rearm) else $error("idle set before a frame"); // R20
	// a held break_send chains breaks with only the one idle clock between
	sequence s_brk_end;
		s.tx_st == TX_BRK && s.tx_left == 4'h1 && s.tx_baud == `UACS_BIT_LAST ##1
			s.ctrl2[`UACS_C2_BREAK_SEND] && s.ctrl2[`UACS_C2_XMIT_ON] && s.te_d && !s.pre_pend;
	endsequence
	property p_brk_hold;
		s_brk_end |=> s.tx_st == TX_BRK;
	endproperty
	a_brk_hold: assert property (p_brk_hold) else $error("held break did not repeat"); // R11
	// long breaks carry three extra zero bits
	sequence s_lbrk_start;
		s.tx_st == TX_IDLE && s.long_brk && !m_9 ##1 s.tx_st == TX_BRK;
	endsequence
	property p_lbrk_len;
		s_lbrk_start |-> ##BRK_LONG s.tx_st == TX_BRK && !txd_o ##1 s.tx_st == TX_IDLE;
	endproperty
	a_lbrk_len: assert property (p_lbrk_len) else $error("long break length wrong"); // R24
endmodule
`default_nettype wire

// File: test/uacs_remote_model.sv
// far-side serial device: sends frames, captures frames, measures low runs
`timescale 1ns/1ps
`default_nettype none
module uacs_remote_model (
	input  wire logic  clk_i,   // shared clock, 16 clocks a bit
	input  wire logic  line_i,  // serial out pin level
	output logic       rxd_o,   // drives the receive pin
	output logic [15:0] low_o   // length of the last low run, clocks
);
	logic [15:0] run = 16'h0;  // current low run
	initial rxd_o = 1'b1;
	// low runs are measured so that break lengths can be judged
	always @(posedge clk_i) begin
		run <= line_i ? 16'h0 : run + 16'h1;
		if (line_i && run != 16'h0)
			low_o <= run;
	end
	// one 8-bit frame: start low, lsb first, stop high
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd_o <= f[i];
			repeat (16) @(posedge clk_i);
		end
	endtask
	// capture one 8-bit frame; a bounded wait so a silent line cannot hang
	task automatic grab(output logic [7:0] d);
		int n;
		n = 0;
		while (line_i !== 1'b0 && n < 1000) begin
			@(posedge clk_i);
			n++;
		end
		repeat (8) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(posedge clk_i);
			d[i] = line_i;
		end
	endtask
endmodule
`default_nettype wire

// File: test/tb_uacs_top.sv
// testbench of the uart control and status block
`timescale 1ns/1ps
`default_nettype none
module tb_uacs_top;
	import uacs_pkg::*;
	logic          core_clk_i = 1'b0;  // block clock
	logic          rst_b_i = 1'b0;     // reset, active low
	uacs_bus_req_t bus_i = '0;         // register requests
	logic [7:0]    rdata_o;            // read data
	logic          txd_o;              // serial out value
	logic          txd_oe_o;           // serial out enable
	logic          irq_o;              // interrupt request
	logic          rxd;                // receive pin from far side
	logic [15:0]   low;                // last low run on the pin
	logic [7:0]    v;                  // scratch read value
	int            num_errors = 0;     // mismatches
	int            total_checks = 0;   // comparisons
	wire           pin;                // serial out pin
	// pull-up holds the pin high while the block does not drive it
	assign pin = txd_oe_o ? txd_o : 1'b1;
	always #10 core_clk_i = ~core_clk_i;
	uacs_top uacs_top_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i),
		.rdata_o(rdata_o), .rxd_i(rxd), .txd_i(pin), .txd_o(txd_o), .txd_oe_o(txd_oe_o),
		.irq_o(irq_o));
	uacs_remote_model uacs_remote_model_inst (.clk_i(core_clk_i), .line_i(pin),
		.rxd_o(rxd), .low_o(low));
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk_i);
		bus_i <= '0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk_i);
		bus_i <= '0;
		#1 d = rdata_o;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		total_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %0t length %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask
	// status read, masked; it also arms the flags that it sees set
	task automatic chk_st(input logic [7:0] mask, input logic [7:0] exp);
		rd(3'h2, v);
		chk(v & mask, exp);
	endtask
	// irq is registered in the same cycle as the control register, so let it land
	task automatic chk_irq(input logic exp);
		repeat (3) @(posedge core_clk_i);
		#1 chk({7'h0, irq_o}, {7'h0, exp});
	endtask
	task automatic t_regs;
		chk_st(8'hff, 8'hc0);
		wr(3'h2, 8'h00);
		chk_st(8'hff, 8'hc0);
		wr(3'h1, 8'hf0);
		rd(3'h1, v);
		chk(v, 8'hf0);
		chk_irq(1'b1);
		wr(3'h1, 8'h40);
		chk_irq(1'b1);
		wr(3'h1, 8'h00);
		chk_irq(1'b0);
		rd(3'h7, v);
		chk(v, 8'h00);
		chk({7'h0, txd_oe_o}, 8'h00);
		$display("register test done");
	endtask
	task automatic t_tx;
		wr(3'h1, 8'h08);
		chk_st(8'hc0, 8'h80);
		chk({7'h0, txd_oe_o}, 8'h01);
		wr(3'h5, 8'h3c);
		chk_st(8'hc0, 8'h00);
		uacs_remote_model_inst.grab(v);
		chk(v, 8'h3c);
		repeat (100) @(posedge core_clk_i);
		chk_st(8'hc0, 8'hc0);
		chk({7'h0, pin}, 8'h01);
		$display("transmit test done");
	endtask
	task automatic t_rx;
		wr(3'h1, 8'h20);
		uacs_remote_model_inst.send(8'h11);
		chk_st(8'h20, 8'h00);
		wr(3'h1, 8'h24);
		uacs_remote_model_inst.send(8'ha3);
		chk_irq(1'b1);
		chk_st(8'h20, 8'h20);
		rd(3'h5, v);
		chk(v, 8'ha3);
		chk_st(8'h20, 8'h00);
		chk_irq(1'b0);
		// a full idle character after the frame raises the idle flag once
		repeat (160) @(posedge core_clk_i);
		chk_st(8'h10, 8'h10);
		rd(3'h5, v);
		chk_st(8'h10, 8'h00);
		wr(3'h1, 8'h08);
		$display("receive test done");
	endtask
	// one toggle of break_send; a second break would still hold the pin low
	task automatic t_brk(input logic [7:0] s2, input logic [15:0] lo, input logic [15:0] hi);
		wr(3'h3, s2);
		// let a preamble queued by an earlier enable drain, or the toggle is missed
		repeat (200) @(posedge core_clk_i);
		wr(3'h1, 8'h09);
		repeat (20) @(posedge core_clk_i);
		wr(3'h1, 8'h08);
		repeat (250) @(posedge core_clk_i);
		chk_rng(low, lo, hi);
		chk({7'h0, pin}, 8'h01);
		wr(3'h3, 8'h00);
		$display("break test done");
	endtask
	// receive pin held low to show that it is cut off in these modes
	task automatic t_loop(input logic [7:0] mode, input logic [7:0] d);
		wr(3'h0, mode);
		uacs_remote_model_inst.rxd_o <= 1'b0;
		wr(3'h1, 8'h0c);
		chk_st(8'h80, 8'h80);
		wr(3'h5, d);
		repeat (400) @(posedge core_clk_i);
		chk_st(8'h20, 8'h20);
		rd(3'h5, v);
		chk(v, d);
		wr(3'h1, 8'h08);
		wr(3'h0, 8'h00);
		uacs_remote_model_inst.rxd_o <= 1'b1;
		$display("loop test done");
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		t_regs;
		t_tx;
		t_rx;
		t_brk(8'h00, 16'd160, 16'd176);
		t_brk(8'h04, 16'd208, 16'd224);
		t_loop(8'h80, 8'h5a);
		t_loop(8'ha0, 8'hc3);
		t_loop(8'h90, 8'h96);
		complete_run;
	end
	// watchdog: the tests need about 3100 cycles
	initial begin
		repeat (20000) @(posedge core_clk_i);
		num_errors++;
		complete_run;
	end
endmodule
`default_nettype wire
